// [common/wrw_pkg.sv]
package wrw_pkg;

   // register map
   localparam logic [7:0] WRW_CR_ADDR = 8'h2a;
   localparam logic [7:0] WRW_CR_RESET = 8'h7f;
   localparam int WRW_ACT_POS = 7;
   localparam int WRW_TOP_POS = 6;
   localparam logic [6:0] WRW_CNT_RESET = 7'h7f;
   localparam logic [6:0] WRW_CNT_TRIP_FROM = 7'h40;
   localparam logic [7:0] WRW_UNMAPPED_READ = 8'h00;

   // timing: sys_clk is the divided oscillator clock
   localparam int WRW_CLK_KHZ = 40000;
   localparam int WRW_STEP_CYCLES = 16384;
   localparam int WRW_SHORT_UNIT = 64;
   localparam int WRW_SHORT_BASE = 192;
   localparam int WRW_PULSE_NS = 500;
   localparam int WRW_PULSE_CYCLES_I = (WRW_PULSE_NS * WRW_CLK_KHZ + 999999) / 1000000;
   localparam int WRW_PULSE_CYCLES = (WRW_PULSE_CYCLES_I < 1) ? 1 : WRW_PULSE_CYCLES_I;
   localparam logic [4:0] WRW_PULSE_LAST = 5'(WRW_PULSE_CYCLES - 1);

   // timebase dependent constants, indexed by timebase_select
   localparam logic [5:0] WRW_MSB_TB0 = 6'd4;
   localparam logic [5:0] WRW_MSB_TB1 = 6'd8;
   localparam logic [5:0] WRW_MSB_TB2 = 6'd20;
   localparam logic [5:0] WRW_MSB_TB3 = 6'd49;
   localparam logic [5:0] WRW_LSB_TB0 = 6'd59;
   localparam logic [5:0] WRW_LSB_TB1 = 6'd53;
   localparam logic [5:0] WRW_LSB_TB2 = 6'd35;
   localparam logic [5:0] WRW_LSB_TB3 = 6'd54;

   typedef enum logic [1:0] {
      WRW_RUN = 2'b01,
      WRW_PULSE = 2'b10
   } wrw_phase_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } wrw_bus_req_t;

   typedef struct packed {
      logic [14:0] cnt;
      logic [3:0] grp;
      logic tick;
   } wrw_psc_state_t;

   typedef struct packed {
      wrw_phase_t phase;
      logic active;
      logic [6:0] counter;
      logic halted;
      logic [4:0] pulse_cnt;
      logic [7:0] rd_data;
      logic rst_pin_out;
      logic rst_pin_oe_n;
      logic watchdog_reset;
   } wrw_state_t;

endpackage : wrw_pkg

// [design/wrw_prescaler.sv]
`timescale 1ns/10ps
`default_nettype none
module wrw_prescaler import wrw_pkg::*; #(
   parameter int STEP_CYCLES = WRW_STEP_CYCLES,
   parameter int SHORT_UNIT = WRW_SHORT_UNIT
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // timebase from the clock controller
   input wire logic [1:0] timebase_select,
   // one-cycle decrement strobe
   output logic tick
);

   wrw_psc_state_t st;
   wrw_psc_state_t next_st;
   logic [5:0] msb;
   logic [5:0] lsb;
   logic [3:0] quarter;
   logic [14:0] period;

   always_comb begin
      case (timebase_select)
         2'b00: begin
            msb = WRW_MSB_TB0;
            lsb = WRW_LSB_TB0;
         end
         2'b01: begin
            msb = WRW_MSB_TB1;
            lsb = WRW_LSB_TB1;
         end
         2'b10: begin
            msb = WRW_MSB_TB2;
            lsb = WRW_LSB_TB2;
         end
         default: begin
            msb = WRW_MSB_TB3;
            lsb = WRW_LSB_TB3;
         end
      endcase
   end

   // after each quarter-msb group of full steps one step is shortened
   assign quarter = 4'(msb >> 2);
   assign period = (st.grp >= quarter) ?
      15'((WRW_SHORT_BASE + int'(lsb)) * SHORT_UNIT) : 15'(STEP_CYCLES);

   // free running: never cleared by a control write, hence the min/max spread
   always_comb begin
      next_st = st;
      next_st.tick = 1'b0;
      if (st.cnt >= period - 15'd1) begin
         next_st.cnt = 15'd0;
         next_st.tick = 1'b1;
         next_st.grp = (st.grp >= quarter) ? 4'd0 : st.grp + 4'd1;
      end else begin
         next_st.cnt = st.cnt + 15'd1;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign tick = st.tick;

endmodule : wrw_prescaler
`default_nettype wire

// [design/wrw_watchdog.sv]
// What this block does
// - counter decrements every 16384 sys_clk cycles
// - six low bits program 64 timeout steps
// - active and 40h to 3Fh: reset pulse
// - counter keeps counting even when inactive
// - reset deactivates; only reset clears activation
// - write active with top bit clear resets
// - halt instruction while active causes reset when halt_reset_option is set; without it the halt freezes the counter
// - write to reset delay varies with prescaler
// - base timeouts from lsb and 16384 periods
// - timebase select picks msb and lsb constants
// - quarter-msb groups shorten one step each
// - timeout count is six low counter bits
// - control resets to 7Fh; bit7 activation
// - hardware option makes the watchdog trip as if always active; watchdog_active and read-back bit7 still show the activation bit
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module wrw_watchdog import wrw_pkg::*; #(
   parameter int STEP_CYCLES = WRW_STEP_CYCLES,
   parameter int SHORT_UNIT = WRW_SHORT_UNIT
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // register port
   input wire wrw_bus_req_t bus_req,
   output logic [7:0] rd_data,
   // chip configuration and cpu events
   input wire logic [1:0] timebase_select,
   input wire logic hw_watchdog_option,
   input wire logic halt_reset_option,
   input wire logic halt_exec,
   input wire logic wake_event,
   // open-drain reset pin and status
   output logic rst_pin_out,
   output logic rst_pin_oe_n,
   output logic watchdog_reset,
   output logic watchdog_active
);

   wrw_state_t st;
   wrw_state_t next_st;
   logic tick;
   logic eff_active;
   logic wr_cr;
   logic rd_cr;
   logic soft_trip;
   logic count_trip;
   logic halt_trip;
   logic [6:0] dec_value;

   wrw_prescaler #(
      .STEP_CYCLES(STEP_CYCLES),
      .SHORT_UNIT(SHORT_UNIT)
   ) u_prescaler (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .timebase_select(timebase_select),
      .tick(tick)
   );

   function automatic logic cr_hit(input wrw_bus_req_t req);
      cr_hit = (req.addr == WRW_CR_ADDR);
   endfunction : cr_hit

   assign wr_cr = bus_req.wr && cr_hit(bus_req);
   assign rd_cr = bus_req.rd && cr_hit(bus_req);

   // the option byte overrides the activation bit
   assign eff_active = st.active || hw_watchdog_option;

   // software reset: activation set with the top bit clear
   assign soft_trip = wr_cr && bus_req.wdata[WRW_ACT_POS] && !bus_req.wdata[WRW_TOP_POS];

   // only the 40h to 3Fh step trips; a write wins over a same-cycle tick
   assign dec_value = st.counter - 7'd1;
   assign count_trip = !wr_cr && tick && !st.halted && eff_active
      && (st.counter == WRW_CNT_TRIP_FROM);

   assign halt_trip = halt_exec && eff_active && halt_reset_option;

   always_comb begin
      next_st = st;
      next_st.rd_data = rd_cr ? {st.active, st.counter} : WRW_UNMAPPED_READ;
      case (st.phase)
         WRW_RUN: begin
            // decrements whether active or not
            if (tick && !st.halted) begin
               next_st.counter = dec_value;
            end
            if (wr_cr) begin
               // all seven bits load at once; the step count is bits 5:0
               next_st.counter = bus_req.wdata[6:0];
               // activation is sticky until reset
               next_st.active = st.active || bus_req.wdata[WRW_ACT_POS];
               next_st.halted = 1'b0;
            end
            // halt without reset freezes the counter until a wake event or a control write; a halt wins a tie
            if (wake_event) begin
               next_st.halted = 1'b0;
            end
            if (halt_exec && !halt_trip) begin
               next_st.halted = 1'b1;
            end
            if (soft_trip || count_trip || halt_trip) begin
               next_st.phase = WRW_PULSE;
               next_st.pulse_cnt = 5'd0;
               next_st.rst_pin_oe_n = 1'b0;
               next_st.watchdog_reset = 1'b1;
            end
         end
         WRW_PULSE: begin
            // pin held low for the pulse time; writes are ignored meanwhile
            if (st.pulse_cnt == WRW_PULSE_LAST) begin
               next_st.phase = WRW_RUN;
               next_st.rst_pin_oe_n = 1'b1;
               next_st.watchdog_reset = 1'b0;
               // own reset state: deactivated, counter back to 7Fh
               next_st.active = WRW_CR_RESET[WRW_ACT_POS];
               next_st.counter = WRW_CNT_RESET;
               next_st.halted = 1'b0;
            end else begin
               next_st.pulse_cnt = st.pulse_cnt + 5'd1;
            end
         end
         default: begin
            next_st.phase = WRW_RUN;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         st.phase <= WRW_RUN;
         st.active <= WRW_CR_RESET[WRW_ACT_POS];
         st.counter <= WRW_CNT_RESET;
         st.halted <= 1'b0;
         st.pulse_cnt <= 5'd0;
         st.rd_data <= 8'h00;
         st.rst_pin_out <= 1'b0;
         st.rst_pin_oe_n <= 1'b1;
         st.watchdog_reset <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   assign rd_data = st.rd_data;
   assign rst_pin_out = st.rst_pin_out;
   assign rst_pin_oe_n = st.rst_pin_oe_n;
   assign watchdog_reset = st.watchdog_reset;
   assign watchdog_active = st.active;

endmodule : wrw_watchdog
`default_nettype wire

// [dv/wrw_watchdog_properties.sv]
`timescale 1ns/10ps
`default_nettype none
module wrw_watchdog_properties import wrw_pkg::*; (
   // clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // register port
   input wire wrw_bus_req_t bus_req,
   input wire logic [7:0] rd_data,
   // configuration and events
   input wire logic [1:0] timebase_select,
   input wire logic hw_watchdog_option,
   input wire logic halt_reset_option,
   input wire logic halt_exec,
   input wire logic wake_event,
   // reset pin and status
   input wire logic rst_pin_out,
   input wire logic rst_pin_oe_n,
   input wire logic watchdog_reset,
   input wire logic watchdog_active
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   // writes during the pulse are refused, so leave them out
   logic cw;
   assign cw = bus_req.wr && bus_req.addr == WRW_CR_ADDR && !watchdog_reset;
   // cycles the reset output has stood high so far; the pulse is too long to unroll
   logic [7:0] hi_run;
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         hi_run <= 8'h00;
      end else if (watchdog_reset) begin
         hi_run <= hi_run + 8'h01;
      end else begin
         hi_run <= 8'h00;
      end
   end
   sequence pulse_s;
      !watchdog_reset && hi_run == 8'(WRW_PULSE_CYCLES);
   endsequence
   sw_reset_a: assert property (cw && bus_req.wdata[7:6] == 2'b10 |=> watchdog_reset)
      else $error("no software reset");
   pulse_len_a: assert property ($fell(watchdog_reset) |-> pulse_s)
      else $error("pulse length");
   pulse_max_a: assert property (watchdog_reset |-> hi_run < 8'(WRW_PULSE_CYCLES))
      else $error("pulse too long");
   pin_drive_a: assert property (watchdog_reset != rst_pin_oe_n && !rst_pin_out)
      else $error("pin drive");
   halt_reset_a: assert property (halt_exec && halt_reset_option && !watchdog_reset
      && (watchdog_active || hw_watchdog_option) |=> watchdog_reset) else $error("halt reset");
   read_ctl_a: assert property (bus_req.rd && bus_req.addr == WRW_CR_ADDR
      |=> rd_data[7] == $past(watchdog_active)) else $error("read active bit");
   activate_a: assert property (cw && bus_req.wdata[7:6] == 2'b11 |=> watchdog_active)
      else $error("not activated");
   sticky_act_a: assert property (watchdog_active && !watchdog_reset |=> watchdog_active)
      else $error("activation lost");
   release_a: assert property ($fell(watchdog_reset) |-> !watchdog_active)
      else $error("active after reset");
endmodule : wrw_watchdog_properties
`default_nettype wire

// [dv/wrw_reset_pin_model.sv]
`timescale 1ns/10ps
`default_nettype none
module wrw_reset_pin_model (
   // pin drive from the block
   input wire logic sys_clk,
   input wire logic rst_pin_out,
   input wire logic rst_pin_oe_n,
   // length of the last low period
   output logic [7:0] low_cycles
);
   logic pin;
   logic [7:0] run = 8'h00;
   // the pin has a pull-up, so a released pin reads high
   assign pin = rst_pin_oe_n ? 1'b1 : rst_pin_out;
   initial low_cycles = 8'h00;
   always @(posedge sys_clk) begin
      if (!pin) run <= run + 8'h01;
      else if (run != 8'h00) begin
         low_cycles <= run;
         run <= 8'h00;
      end
   end
endmodule : wrw_reset_pin_model
`default_nettype wire

// [dv/wrw_watchdog_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module wrw_watchdog_tb import wrw_pkg::*;;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   wrw_bus_req_t req = '0;
   logic [1:0] tbs = 2'b00;
   logic hw = 1'b0;
   logic hro = 1'b0;
   logic halt = 1'b0;
   logic wake = 1'b0;
   logic [7:0] rdat, low, v;
   logic pout, oen, wrst, wact;
   int bad_count = 0;
   int checks_done = 0;
   int i;
   // write data beside the read-back it should give, in order
   logic [15:0] rows [4] = '{16'h4545, 16'h7f7f, 16'hc5c5, 16'h7fff};
   // short step counts keep the run brief
   wrw_watchdog #(.STEP_CYCLES(64), .SHORT_UNIT(1)) u_dut (.sys_clk(clk), .resetn(rstn),
      .bus_req(req), .rd_data(rdat), .timebase_select(tbs), .hw_watchdog_option(hw),
      .halt_reset_option(hro), .halt_exec(halt), .wake_event(wake), .rst_pin_out(pout),
      .rst_pin_oe_n(oen), .watchdog_reset(wrst), .watchdog_active(wact));
   wrw_reset_pin_model u_pin (.sys_clk(clk), .rst_pin_out(pout), .rst_pin_oe_n(oen),
      .low_cycles(low));
   initial forever #12.5 clk = ~clk;
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : test_done
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      checks_done++;
      if (s !== e) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic rst;
      rstn <= 1'b0;
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
   endtask : rst
   // each call lets one more edge pass, so the next call never reassigns req in this step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      req <= '{1'b1, 1'b0, a, d};
      @(posedge clk);
      req <= '0;
      @(posedge clk);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      req <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge clk);
      req <= '0;
      #1 v = rdat;
      chk("rd_data", e, v);
      @(posedge clk);
   endtask : rd
   // wait a bounded time for the pulse, then its length and the state after it
   task automatic trip(input int n);
      i = 0;
      while (wrst !== 1'b1 && i < n) begin
         @(posedge clk);
         i++;
      end
      chk("watchdog_reset", 8'h01, {7'h00, wrst});
      // the pulse is seen one edge late; read right after its release, before a tick lands
      repeat (WRW_PULSE_CYCLES - 1) @(posedge clk);
      rd(WRW_CR_ADDR, WRW_CR_RESET);
      chk("low_cycles", 8'(WRW_PULSE_NS / 25), low);
   endtask : trip
   initial begin
      rst();
      rd(WRW_CR_ADDR, WRW_CR_RESET);
      for (int r = 0; r < 4; r++) begin
         wr(WRW_CR_ADDR, rows[r][15:8]);
         rd(WRW_CR_ADDR, rows[r][7:0]);
      end
      rst();
      wr(8'h2b, 8'hbf);
      rd(8'h2b, WRW_UNMAPPED_READ);
      chk("watchdog_reset", 8'h00, {7'h00, wrst});
      wr(WRW_CR_ADDR, 8'hbf);
      trip(5);
      wr(WRW_CR_ADDR, 8'hc1);
      trip(1000);
      wr(WRW_CR_ADDR, 8'h50);
      repeat (400) @(posedge clk);
      req <= '{1'b0, 1'b1, WRW_CR_ADDR, 8'h00};
      @(posedge clk);
      req <= '0;
      #1 chk("counting", 8'h01, {7'h00, rdat < 8'h50 && wrst === 1'b0});
      hw <= 1'b1;
      wr(WRW_CR_ADDR, 8'h41);
      trip(1000);
      hw <= 1'b0;
      hro <= 1'b1;
      wr(WRW_CR_ADDR, 8'hff);
      halt <= 1'b1;
      @(posedge clk);
      halt <= 1'b0;
      trip(5);
      // without the halt option a halt freezes the counter: no reset until a wake
      hro <= 1'b0;
      wr(WRW_CR_ADDR, 8'hc1);
      halt <= 1'b1;
      @(posedge clk);
      halt <= 1'b0;
      i = 0;
      repeat (600) begin
         @(posedge clk);
         if (wrst !== 1'b0) i++;
      end
      chk("halt_freeze", 8'h00, 8'(i));
      wake <= 1'b1;
      @(posedge clk);
      wake <= 1'b0;
      trip(1000);
      test_done();
   end
   initial begin
      #(25 * 20000);
      bad_count++;
      test_done();
   end
endmodule : wrw_watchdog_tb
bind wrw_watchdog wrw_watchdog_properties u_props (.*);
`default_nettype wire
